//--- logic/ptwr_reader.sv
// Purpose: Paper tape word reader with single-step and manual execution
// Assumes: Tape characters arrive with valid/ready on the system clock
// Notes:   Sequencer issues board or manual instructions on resume
`timescale 1ns/1ns
module ptwr_reader
    import ptwr_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 srst,
    // Tape mechanism side
    input  wire logic                 tape_valid,
    input  wire logic [7:0]           tape_char,
    output logic                      tape_ready,
    input  wire logic                 five_channel,
    // Read operations from the sequencer
    input  wire logic                 read_data_req,
    input  wire logic                 read_instr_req,
    output logic                      read_busy,
    output logic                      read_done,
    // Accumulator and instruction results
    output logic                      acc_load,
    output ptwr_pkg::ptwr_word_t      acc_word,
    output logic                      tape_instr_valid,
    output ptwr_pkg::ptwr_instr_t     tape_instr,
    // Alarm
    output logic                      alarm,
    input  wire logic                 alarm_clear,
    // Stepping and manual control
    input  wire logic                 resume_request,
    input  wire logic                 single_step,
    input  wire logic                 program_source_select,
    input  wire ptwr_pkg::ptwr_instr_t manual_instr,
    input  wire ptwr_pkg::ptwr_instr_t board_instr,
    input  wire logic                 exec_done,
    input  wire logic                 halt_hit,
    output logic                      exec_valid,
    output ptwr_pkg::ptwr_instr_t     exec_instr,
    output logic                      exec_manual,
    output logic                      step_advance,
    output logic                      running
);
    import ptwr_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE, ST_SEEK, ST_DATA, ST_INSTR, ST_ALARM
    } ptwr_rd_state_t;

    typedef enum logic [1:0] {
        SQ_STOP, SQ_ISSUE, SQ_WAIT
    } ptwr_sq_state_t;

    ptwr_rd_state_t state_r;
    ptwr_rd_state_t state_nxt;
    ptwr_sq_state_t sq_r;
    ptwr_sq_state_t sq_nxt;

    logic        buf_valid;
    logic [7:0]  buf_data;
    logic        buf_pop;
    ptwr_char_t  ch;

    logic        mix_r;
    logic [3:0]  dcnt_r;
    logic [47:0] shift_r;
    logic        neg_r;
    logic [1:0]  icnt_r;
    logic [5:0]  ich0_r;
    logic [5:0]  ich1_r;

    logic        reading;
    logic        take;
    logic        is_instr_ch;
    logic        bad_parity;
    logic        too_long;
    logic        empty_word;
    logic        word_end;
    logic        instr_end;
    logic        fault;
    logic        start_rd;
    logic [47:0] shift_nxt;
    ptwr_instr_t instr_nxt;

    // Character buffer; a stalled parse backs up to the mechanism
    ptwr_fifo #(
        .WIDTH (CHAR_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .srst      (srst),
        .in_valid  (tape_valid),
        .in_data   (tape_char),
        .in_ready  (tape_ready),
        .out_valid (buf_valid),
        .out_data  (buf_data),
        .out_ready (buf_pop)
    );

    ptwr_char_decode u_dec (
        .raw          (buf_data),
        .five_channel (five_channel),
        .ch           (ch)
    );

    // Character consumption and error detection
    assign reading     = (state_r == ST_SEEK) || (state_r == ST_DATA)
                      || (state_r == ST_INSTR);
    assign buf_pop     = reading && buf_valid;
    assign take        = buf_pop && !ch.perr;
    assign bad_parity  = buf_pop && ch.perr;
    assign is_instr_ch = (ch.kind == CK_CODE) || (ch.kind == CK_DIGIT);
    assign too_long    = (ch.kind == CK_DIGIT)
                      && (dcnt_r == DIGIT_MAX);
    assign empty_word  = (ch.kind == CK_END) && (dcnt_r == DIGIT_NONE);
    assign word_end    = take && (state_r == ST_DATA) && (ch.kind == CK_END)
                      && !empty_word;
    assign instr_end   = take && (state_r == ST_INSTR) && is_instr_ch
                      && (icnt_r == ICHAR_LAST);
    assign start_rd    = (read_data_req || read_instr_req) && !read_busy;

    // Malformed items stop the transfer like a parity failure
    assign fault = bad_parity
                || (take && (state_r == ST_DATA)
                    && (too_long || empty_word || (ch.kind == CK_BEGIN)
                        || (ch.kind == CK_CODE)))
                || (take && (state_r == ST_INSTR) && !is_instr_ch);

    // Each digit enters at the right, so leading zeros remain as padding
    assign shift_nxt = {shift_r[WORD_W-DIGIT_W-1:0], ch.digit};

    // Tape instruction packed in plugboard field order
    assign instr_nxt = '{op: ich0_r, field_a: ich1_r, field_b: ch.code};

    // Parser next state
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: begin
                if (start_rd) begin
                    state_nxt = ST_SEEK;
                end
            end
            ST_SEEK: begin
                if (take && ch.kind == CK_BEGIN) begin
                    state_nxt = ST_DATA;
                end else if (take && mix_r && is_instr_ch) begin
                    state_nxt = ST_INSTR;
                end
            end
            ST_DATA: begin
                if (word_end) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_INSTR: begin
                if (instr_end) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_ALARM: begin
                if (alarm_clear) begin
                    state_nxt = ST_IDLE;
                end
            end
        endcase
        if (fault) begin
            state_nxt = ST_ALARM;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Read mode latched at request; data-only skips stray characters
    always_ff @(posedge clk) begin
        if (srst) begin
            mix_r <= 1'b0;
        end else if (start_rd && state_r == ST_IDLE) begin
            mix_r <= read_instr_req && !read_data_req;
        end
    end

    // Digit assembly; a fresh begin symbol clears the word
    always_ff @(posedge clk) begin
        if (srst) begin
            shift_r <= WORD_ZERO;
            dcnt_r  <= DIGIT_NONE;
            neg_r   <= 1'b0;
        end else if (take && state_r == ST_SEEK) begin
            shift_r <= WORD_ZERO;
            dcnt_r  <= DIGIT_NONE;
            neg_r   <= 1'b0;
        end else if (take && state_r == ST_DATA && !fault) begin
            if (ch.kind == CK_DIGIT) begin
                shift_r <= shift_nxt;
                dcnt_r  <= dcnt_r + 4'h1;
            end else if (ch.kind == CK_MINUS) begin
                neg_r <= 1'b1;
            end
        end
    end

    // Instruction character gathering, three per instruction
    always_ff @(posedge clk) begin
        if (srst) begin
            icnt_r <= ICHAR_NONE;
            ich0_r <= FIELD_ZERO;
            ich1_r <= FIELD_ZERO;
        end else if (take && state_r == ST_SEEK && mix_r && is_instr_ch) begin
            ich0_r <= ch.code;
            icnt_r <= 2'h1;
        end else if (take && state_r == ST_INSTR && is_instr_ch) begin
            ich1_r <= ch.code;
            icnt_r <= icnt_r + 2'h1;
        end
    end

    // Results; the accumulator only loads on a clean end symbol
    always_ff @(posedge clk) begin
        if (srst) begin
            acc_load         <= 1'b0;
            acc_word         <= '{neg: 1'b0, mag: WORD_ZERO};
            tape_instr_valid <= 1'b0;
            tape_instr       <= '0;
            read_done        <= 1'b0;
        end else begin
            acc_load         <= word_end;
            tape_instr_valid <= instr_end;
            read_done        <= word_end || instr_end;
            if (word_end) begin
                acc_word <= '{neg: neg_r, mag: shift_r};
            end
            if (instr_end) begin
                tape_instr <= instr_nxt;
            end
        end
    end

    // Busy spans request to result; alarm holds until cleared
    always_ff @(posedge clk) begin
        if (srst) begin
            read_busy <= 1'b0;
            alarm     <= 1'b0;
        end else begin
            read_busy <= (state_nxt != ST_IDLE) && (state_nxt != ST_ALARM);
            alarm     <= (state_nxt == ST_ALARM);
        end
    end

    // Sequencer: stop, issue one instruction, wait for its completion
    always_comb begin
        sq_nxt = sq_r;
        unique case (sq_r)
            SQ_STOP: begin
                if (resume_request && !alarm) begin
                    sq_nxt = SQ_WAIT;
                end
            end
            SQ_ISSUE: begin
                sq_nxt = SQ_WAIT;
            end
            SQ_WAIT: begin
                if (exec_done) begin
                    sq_nxt = (exec_manual || single_step || halt_hit || alarm)
                           ? SQ_STOP : SQ_ISSUE;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            sq_r <= SQ_STOP;
        end else begin
            sq_r <= sq_nxt;
        end
    end

    // Issue path; manual fields never touch the step pointer
    always_ff @(posedge clk) begin
        if (srst) begin
            exec_valid   <= 1'b0;
            exec_instr   <= '0;
            exec_manual  <= 1'b0;
            step_advance <= 1'b0;
            running      <= 1'b0;
        end else begin
            exec_valid   <= 1'b0;
            step_advance <= sq_r == SQ_WAIT && exec_done
                            && !exec_manual;
            running      <= (sq_nxt != SQ_STOP);
            if (sq_r == SQ_STOP && sq_nxt == SQ_WAIT) begin
                exec_valid  <= 1'b1;
                exec_manual <= program_source_select;
                exec_instr  <= program_source_select ? manual_instr
                                                     : board_instr;
            end else if (sq_r == SQ_ISSUE) begin
                exec_valid  <= 1'b1;
                exec_manual <= 1'b0;
                exec_instr  <= board_instr;
            end
        end
    end
endmodule : ptwr_reader

//--- logic/ptwr_pkg.sv
// Purpose: Shared constants and types for the paper tape word reader
// Assumes: One system clock, synchronous active-high reset
// Notes:   Character codes are local to this reader and its tape punch
package ptwr_pkg;

    // Word and tape geometry
    localparam int DIGITS      = 12;
    localparam int DIGIT_W     = 4;
    localparam int WORD_W      = 48;
    localparam int CHAR_W      = 8;
    localparam int FIFO_DEPTH  = 16;
    localparam int INSTR_CHARS = 3;

    // Counter widths sized for the counts above
    localparam logic [3:0] DIGIT_MAX  = 4'hC;
    localparam logic [3:0] DIGIT_NONE = 4'h0;
    localparam logic [1:0] ICHAR_LAST = 2'h2;
    localparam logic [1:0] ICHAR_NONE = 2'h0;
    localparam logic [3:0] DIGIT_TOP  = 4'h9;

    // Eight-channel symbols in channels 1..7, channel 8 is parity
    localparam logic [6:0] CH8_BEGIN = 7'h40;
    localparam logic [6:0] CH8_END   = 7'h41;
    localparam logic [6:0] CH8_MINUS = 7'h42;
    localparam logic       PARITY_ODD = 1'b1;

    // Five-channel symbols, no parity channel
    localparam logic [4:0] CH5_BEGIN = 5'h10;
    localparam logic [4:0] CH5_END   = 5'h11;
    localparam logic [4:0] CH5_MINUS = 5'h12;

    // Values after reset
    localparam logic [47:0] WORD_ZERO  = 48'h0000_0000_0000;
    localparam logic [5:0]  FIELD_ZERO = 6'h00;

    typedef enum logic [2:0] {
        CK_DIGIT, CK_BEGIN, CK_END, CK_MINUS, CK_CODE
    } ptwr_kind_t;

    // One decoded tape character
    typedef struct packed {
        ptwr_kind_t  kind;
        logic [3:0]  digit;
        logic [5:0]  code;
        logic        perr;
    } ptwr_char_t;

    // Instruction in plugboard coding: operation and two fields
    typedef struct packed {
        logic [5:0] op;
        logic [5:0] field_a;
        logic [5:0] field_b;
    } ptwr_instr_t;

    // Signed decimal word, magnitude as twelve BCD digits
    typedef struct packed {
        logic        neg;
        logic [47:0] mag;
    } ptwr_word_t;

endpackage : ptwr_pkg

//--- logic/ptwr_fifo.sv
// Purpose: Character buffer between the tape mechanism and the decoder
// Assumes: Single clock, synchronous reset
// Notes:   Ready is registered so it leaves the block from a flip-flop
`timescale 1ns/1ns
module ptwr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    output logic                  out_valid,
    output logic      [WIDTH-1:0] out_data,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wr_r;
    logic [AW-1:0]    rd_r;
    logic [AW:0]      cnt_r;
    logic [AW:0]      cnt_nxt;
    logic             push;
    logic             pop;

    // Push only while room is advertised, pop only while data is held
    assign push      = in_valid && in_ready;
    assign pop       = out_ready && out_valid;
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem_r[rd_r];
    assign cnt_nxt   = cnt_r + (AW+1)'(push) - (AW+1)'(pop);

    // Storage written by index
    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wr_r] <= in_data;
        end
    end

    // Pointers and occupancy; ready drops as the last slot fills
    always_ff @(posedge clk) begin
        if (srst) begin
            wr_r     <= '0;
            rd_r     <= '0;
            cnt_r    <= '0;
            in_ready <= 1'b0;
        end else begin
            wr_r     <= push ? AW'(wr_r + 1'b1) : wr_r;
            rd_r     <= pop ? AW'(rd_r + 1'b1) : rd_r;
            cnt_r    <= cnt_nxt;
            in_ready <= (cnt_nxt < (AW+1)'(DEPTH));
        end
    end
endmodule : ptwr_fifo

//--- logic/ptwr_char_decode.sv
// Purpose: Classify one raw tape character and check its parity
// Assumes: Eight-channel parity is odd over all eight channels
// Notes:   Purely combinational; five-channel tape has no check
`timescale 1ns/1ns
module ptwr_char_decode
    import ptwr_pkg::*;
(
    input  wire logic [7:0] raw,
    input  wire logic       five_channel,
    output ptwr_pkg::ptwr_char_t ch
);
    logic [6:0] sym8;
    logic [4:0] sym5;
    logic       is_begin;
    logic       is_end;
    logic       is_minus;
    logic       is_digit;

    // Symbol selection per tape width
    assign sym8     = raw[6:0];
    assign sym5     = raw[4:0];
    assign is_begin = five_channel ? (sym5 == CH5_BEGIN) : (sym8 == CH8_BEGIN);
    assign is_end   = five_channel ? (sym5 == CH5_END) : (sym8 == CH8_END);
    assign is_minus = five_channel ? (sym5 == CH5_MINUS) : (sym8 == CH8_MINUS);
    assign is_digit = five_channel ? (sym5 <= {1'b0, DIGIT_TOP})
                                   : (sym8 <= {3'h0, DIGIT_TOP});

    // Classification; digits double as instruction characters
    assign ch.kind  = is_begin ? CK_BEGIN :
                      is_end   ? CK_END   :
                      is_minus ? CK_MINUS :
                      is_digit ? CK_DIGIT : CK_CODE;
    assign ch.digit = raw[3:0];
    assign ch.code  = five_channel ? {1'b0, sym5} : raw[5:0];
    assign ch.perr  = !five_channel && ((^raw) != PARITY_ODD);
endmodule : ptwr_char_decode

//--- tb/ptwr_reader_assertions.sv
// Purpose: Port-level properties of the tape word reader
// Assumes: One clock domain, synchronous active-high reset
// Notes:   Bound to every reader instance at the foot of this file
`timescale 1ns/1ns
module ptwr_reader_assertions
    import ptwr_pkg::*;
(
    input wire logic                  clk,
    input wire logic                  srst,
    input wire logic                  read_busy,
    input wire logic                  read_done,
    input wire logic                  acc_load,
    input wire ptwr_pkg::ptwr_word_t  acc_word,
    input wire logic                  tape_instr_valid,
    input wire logic                  alarm,
    input wire logic                  alarm_clear,
    input wire logic                  resume_request,
    input wire logic                  single_step,
    input wire logic                  program_source_select,
    input wire ptwr_pkg::ptwr_instr_t manual_instr,
    input wire ptwr_pkg::ptwr_instr_t board_instr,
    input wire logic                  exec_done,
    input wire logic                  halt_hit,
    input wire logic                  exec_valid,
    input wire ptwr_pkg::ptwr_instr_t exec_instr,
    input wire logic                  exec_manual,
    input wire logic                  step_advance,
    input wire logic                  running
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    // Tape read results: a load always closes its read
    a_load_done:
        assert property (acc_load |-> read_done && !read_busy)
        else $error("load without done");
    // The word may only move with a load, so a fault cannot touch it
    a_acc_hold:
        assert property (!$stable(acc_word) |-> acc_load)
        else $error("word changed without load");
    a_fault_idle:
        assert property ($rose(alarm) |-> !read_busy && !acc_load)
        else $error("fault left read active");
    a_alarm_hold:
        assert property (alarm && !alarm_clear |=> alarm)
        else $error("alarm dropped");
    a_alarm_clear:
        assert property (alarm && alarm_clear |=> !alarm)
        else $error("alarm not cleared");
    // Sequencer: source of the issued instruction and what follows it
    a_exec_src:
        assert property (resume_request && !running && !alarm |=>
            exec_valid && exec_instr == ($past(program_source_select) ?
            $past(manual_instr) : $past(board_instr)))
        else $error("wrong instruction issued");
    a_step_next:
        assert property (exec_done && running && !single_step &&
            !exec_manual && !halt_hit && !alarm |=> step_advance ##1
            exec_valid)
        else $error("normal run did not continue");
    a_step_stop:
        assert property (exec_done && running && (single_step ||
            exec_manual) |=> !exec_valid [*3] ##0 !running)
        else $error("stepping did not stop");
    a_manual_fix:
        assert property (exec_manual |-> !step_advance)
        else $error("manual moved the program");

    c_neg_word: cover property (acc_load && acc_word.neg);
    c_instr: cover property (tape_instr_valid);
    c_fault: cover property ($rose(alarm));
endmodule : ptwr_reader_assertions

bind ptwr_reader ptwr_reader_assertions i_chk (.*);

//--- tb/ptwr_tape_model.sv
// Purpose: Behavioural tape mechanism feeding the reader
// Assumes: Characters arrive already encoded for the tape format
// Notes:   Slow mode withholds new characters on every other cycle
`timescale 1ns/1ns
module ptwr_tape_model (
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       slow,
    input  wire logic       tape_ready,
    output logic            tape_valid,
    output logic [7:0]      tape_char
);
    logic [7:0] q[$];
    logic       took_r;
    logic       gap_r;

    // Tape holds whole items, three characters per instruction
    task automatic put(input logic [7:0] c);
        q.push_back(c);
    endtask : put

    initial begin
        tape_valid = 1'b0;
        tape_char = 8'h00;
        took_r = 1'b0;
        gap_r = 1'b0;
    end

    // A character counts as read only at an edge with ready high
    always @(posedge clk) took_r <= tape_valid & tape_ready;

    // Hold until taken; idle line flips so stale data never looks valid
    always @(negedge clk) begin
        if (took_r)
            void'(q.pop_front());
        gap_r <= ~gap_r;
        if (tape_valid && !took_r) begin
        end else if (srst || q.size() == 0 || (slow && gap_r)) begin
            tape_valid <= 1'b0;
            tape_char <= ~tape_char;
        end else begin
            tape_valid <= 1'b1;
            tape_char <= q[0];
        end
    end
endmodule : ptwr_tape_model

//--- tb/paper_tape_word_reader_tb.sv
// Purpose: Self-checking bench for the tape word reader
// Assumes: Bench drives inputs at the falling clock edge
// Notes:   Only mismatches and the verdict are printed
`timescale 1ns/1ns
module paper_tape_word_reader_tb;
    import ptwr_pkg::*;
    logic        clk, srst, slow, five_channel, tape_valid, tape_ready;
    logic [7:0]  tape_char;
    logic        read_data_req, read_instr_req, read_busy, read_done;
    logic        acc_load, tape_instr_valid, alarm, alarm_clear;
    logic        resume_request, single_step, program_source_select;
    logic        exec_done, halt_hit, exec_valid, exec_manual;
    logic        step_advance, running, got_ld, got_iv;
    ptwr_word_t  acc_word;
    ptwr_instr_t tape_instr, manual_instr, board_instr, exec_instr;
    int          err_total, checks;

    ptwr_reader i_dut (.*);
    ptwr_tape_model i_tape (.*);

    // 25 MHz system clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic final_report;
        if (err_total == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : final_report

    // One compare per kind of result; x never matches
    task automatic cmp_w(input ptwr_word_t g, input ptwr_word_t e);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("mismatch t=%0t word %h exp %h", $time, g, e);
        end
    endtask : cmp_w
    task automatic cmp_i(input ptwr_instr_t g, input ptwr_instr_t e);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("mismatch t=%0t instr %h exp %h", $time, g, e);
        end
    endtask : cmp_i
    task automatic cmp_b(input logic g, input logic e);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("mismatch t=%0t flag %b exp %b", $time, g, e);
        end
    endtask : cmp_b

    // Eight-channel symbol with odd parity over all channels
    function automatic logic [7:0] c8(input logic [6:0] s);
        return {~^s, s};
    endfunction : c8
    task automatic feed(input logic [7:0] s[$]);
        foreach (s[i]) i_tape.put(five_channel ? s[i] : c8(s[i][6:0]));
    endtask : feed

    function automatic logic pick(input int k);
        case (k)
            0: return read_done | alarm;
            1: return exec_valid;
            2: return step_advance;
            default: return !tape_ready;
        endcase
    endfunction : pick
    // Bounded wait; a hang ends the run as a failure
    task automatic wt(input int k);
        int n;
        n = 0;
        while (pick(k) !== 1'b1) begin
            n++;
            if (n > 400) begin
                err_total++;
                $display("mismatch t=%0t timeout", $time);
                final_report();
            end
            @(negedge clk);
        end
    endtask : wt
    // One-cycle pulse: 0 resume, 1 exec done, 2 alarm clear, 3 data read
    task automatic go(input int k);
        @(negedge clk);
        {resume_request, exec_done, alarm_clear, read_data_req} = 4'h8 >> k;
        @(negedge clk);
        {resume_request, exec_done, alarm_clear, read_data_req} = 4'h0;
    endtask : go
    task automatic rd(input logic instr);
        @(negedge clk);
        read_data_req = !instr;
        read_instr_req = instr;
        @(negedge clk);
        read_data_req = 1'b0;
        read_instr_req = 1'b0;
        wt(0);
        got_ld = acc_load;
        got_iv = tape_instr_valid;
    endtask : rd

    // One-digit word, zero padded and right-justified
    task automatic sc_short;
        feed('{8'h40, 8'h05, 8'h41});
        rd(1'b0);
        cmp_b(got_ld, 1'b1);
        cmp_w(acc_word, {1'b0, 48'h0000_0000_0005});
    endtask : sc_short

    // Buffer filled to refusal while the tape stalls, then drained
    task automatic sc_fill;
        slow = 1'b1;
        feed('{8'h07, 8'h08, 8'h40, 8'h42});
        for (int i = 1; i <= 12; i++) i_tape.put(c8(7'(i % 10)));
        feed('{8'h41});
        wt(3);
        // The model pops on the same falling edge; let one cycle pass
        @(negedge clk);
        cmp_b(logic'(i_tape.q.size() == 1), 1'b1);
        slow = 1'b0;
        rd(1'b0);
        cmp_w(acc_word, {1'b1, 48'h1234_5678_9012});
        cmp_b(tape_ready, 1'b1);
    endtask : sc_fill

    // Instruction padded with ones, then a word, on mixed reads
    task automatic sc_instr;
        feed('{8'h2B, 8'h01, 8'h01, 8'h40, 8'h07, 8'h41});
        rd(1'b1);
        cmp_b(got_iv, 1'b1);
        cmp_i(tape_instr, {6'h2B, 6'h01, 6'h01});
        rd(1'b1);
        cmp_w(acc_word, {1'b0, 48'h0000_0000_0007});
    endtask : sc_instr

    task automatic sc_five;
        five_channel = 1'b1;
        feed('{8'h10, 8'h09, 8'h11});
        rd(1'b0);
        five_channel = 1'b0;
        cmp_w(acc_word, {1'b0, 48'h0000_0000_0009});
    endtask : sc_five

    // Bad parity mid-word: alarm holds, word kept, leftovers skipped
    task automatic sc_parity;
        feed('{8'h40});
        i_tape.put({^7'h03, 7'h03});
        feed('{8'h41});
        rd(1'b0);
        cmp_b(alarm, 1'b1);
        cmp_b(got_ld, 1'b0);
        go(3);
        cmp_b(read_busy, 1'b0);
        cmp_b(alarm, 1'b1);
        cmp_w(acc_word, {1'b0, 48'h0000_0000_0009});
        go(2);
        cmp_b(alarm, 1'b0);
        feed('{8'h40, 8'h04, 8'h41});
        rd(1'b0);
        cmp_w(acc_word, {1'b0, 48'h0000_0000_0004});
    endtask : sc_parity

    // Two normal steps to a halt, one single step, one manual op
    task automatic sc_seq;
        board_instr = 18'h1_2345;
        go(0);
        wt(1);
        cmp_i(exec_instr, 18'h1_2345);
        go(1);
        wt(2);
        board_instr = 18'h2_3456;
        wt(1);
        cmp_i(exec_instr, 18'h2_3456);
        halt_hit = 1'b1;
        go(1);
        halt_hit = 1'b0;
        repeat (3) @(negedge clk);
        cmp_b(running, 1'b0);
        single_step = 1'b1;
        board_instr = 18'h3_0F0F;
        go(0);
        wt(1);
        cmp_i(exec_instr, 18'h3_0F0F);
        go(1);
        repeat (3) @(negedge clk);
        cmp_b(running, 1'b0);
        single_step = 1'b0;
        program_source_select = 1'b1;
        manual_instr = 18'h0_ABCD;
        go(0);
        wt(1);
        cmp_i(exec_instr, 18'h0_ABCD);
        cmp_b(exec_manual, 1'b1);
        go(1);
        repeat (3) @(negedge clk);
        cmp_b(running, 1'b0);
    endtask : sc_seq

    // Reset for four cycles, then run every scenario
    initial begin
        err_total = 0;
        checks = 0;
        srst = 1'b1;
        {read_data_req, read_instr_req, alarm_clear, resume_request} = 4'h0;
        {single_step, program_source_select, exec_done, halt_hit} = 4'h0;
        {five_channel, slow} = 2'h0;
        manual_instr = 18'h0_0000;
        board_instr = 18'h0_0000;
        repeat (4) @(negedge clk);
        srst = 1'b0;
        @(negedge clk);
        sc_short();
        sc_fill();
        sc_instr();
        sc_five();
        sc_parity();
        sc_seq();
        final_report();
    end
endmodule : paper_tape_word_reader_tb
